// *** rtl/emac_irq_cfg.svh ***
// Summary of operation
// RQ1 - queue pointer holds list start; low bits advance, wrap at 1024 or wrap bit
// RQ2 - pointer write taken only while transmit-active bit 3 reads low
// RQ3 - software writes pointer bit 2 as zero to keep bursts inside 1K
// RQ4 - pointer read gives first buffer of frame sent or about to be sent
// RQ5 - receive flags set by hardware only; write one clears; bits 2,1,0
// RQ6 - after an owned descriptor, retry descriptor read at each new frame start
// RQ7 - buffer-unavailable flag set again on every failed descriptor attempt
// RQ8 - frame-received flag set when frames are stored, held until written one
// RQ9 - late grant or bus error on receive sets overrun and reclaims buffer; here only rx_overrun does, rx_bus_error sets bit 11 only
// RQ10 - status bits: 0,1,2,3,4,5,6,7 then 10,11,12,13 as listed
// RQ11 - receive complete set per stored frame; all status cleared by read
// RQ12 - owned receive or transmit descriptor read sets its used-bit flag
// RQ13 - underrun set on late data, bus error, mid-frame owned bit, pointer write
// RQ14 - transmit error set when buffers run out mid-frame
// RQ15 - transmit complete set each time a frame finishes
// RQ16 - receive overrun interrupt set when overrun status flag gets set
// RQ17 - bus error interrupt set on any DMA error response
// RQ18 - pause-received on valid pause frame; pause-zero when pause time hits zero
// RQ19 - management done set when management operation finishes
// RQ20 - enable register: writing one unmasks that source, status layout
// RQ21 - disable register: writing one masks that source, status layout
// RQ22 - mask readback shows masked sources; enable clears, disable sets
// RQ23 - transmit status bit 3 reads high while transmission is active
// RQ24 - interrupt out while any unmasked flag set; zero writes change nothing
`ifndef EMAC_IRQ_CFG_SVH
`define EMAC_IRQ_CFG_SVH
`define ADDR_TSR     32'hfffc4014
`define ADDR_TQP     32'hfffc401c
`define ADDR_RXSTAT  32'hfffc4020
`define ADDR_IRQSTAT 32'hfffc4024
`define ADDR_IRQEN   32'hfffc4028
`define ADDR_IRQDIS  32'hfffc402c
`define ADDR_IRQMASK 32'hfffc4030
`define TSR_ACTIVE   3
`define TQ_LAST_IDX  10'h3ff
`define RXS_BUF_UNAVAIL  0
`define RXS_FRAME_STORED 1
`define RXS_OVERRUN      2
`define RXS_IMPL     32'h00000007
`define IRQ_MGMT_DONE    0
`define IRQ_RX_DONE      1
`define IRQ_RX_OWNED     2
`define IRQ_TX_OWNED     3
`define IRQ_TX_UNDER     4
`define IRQ_RETRY_LIM    5
`define IRQ_TX_EXHAUST   6
`define IRQ_TX_DONE      7
`define IRQ_RX_OVERRUN   10
`define IRQ_BUS_ERROR    11
`define IRQ_PAUSE_RX     12
`define IRQ_PAUSE_ZERO   13
`define IRQ_IMPL     32'h00003cff
`define MASK_RST     32'h00003cff
`define TQP_RST      32'h00000000
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// *** rtl/emac_irq_pkg.sv ***
package emac_irq_pkg;
	// one-cycle event pulses from the dma, mac and management engines
	typedef struct packed {
		logic mgmt_done;
		logic rx_frame_stored;
		logic rx_desc_owned;
		logic rx_frame_start;
		logic rx_desc_ok;
		logic rx_overrun;
		logic rx_bus_error;
		logic tx_desc_owned;
		logic tx_late_data;
		logic tx_bus_error;
		logic tx_owned_mid;
		logic tx_exhausted;
		logic tx_complete;
		logic tx_buf_used;
		logic tx_buf_wrap;
		logic retry_limit;
		logic pause_received;
		logic pause_zero;
	} mac_events_s;
	typedef logic [31:0] word_t;
endpackage

// *** rtl/emac_status_interrupt_regs.sv ***
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "emac_irq_cfg.svh"
module emac_status_interrupt_regs (
	// clock and reset
	input  wire logic                  MCLK_IN,
	input  wire logic                  RESETN_IN,
	// axi4-lite write address
	input  wire emac_irq_pkg::word_t   AWADDR_IN,
	input  wire logic                  AWVALID_IN,
	output logic                       AWREADY_OUT,
	// axi4-lite write data
	input  wire emac_irq_pkg::word_t   WDATA_IN,
	input  wire logic [3:0]            WSTRB_IN,
	input  wire logic                  WVALID_IN,
	output logic                       WREADY_OUT,
	// axi4-lite write response
	output logic [1:0]                 BRESP_OUT,
	output logic                       BVALID_OUT,
	input  wire logic                  BREADY_IN,
	// axi4-lite read address
	input  wire emac_irq_pkg::word_t   ARADDR_IN,
	input  wire logic                  ARVALID_IN,
	output logic                       ARREADY_OUT,
	// axi4-lite read data
	output emac_irq_pkg::word_t        RDATA_OUT,
	output logic [1:0]                 RRESP_OUT,
	output logic                       RVALID_OUT,
	input  wire logic                  RREADY_IN,
	// mac engine events and state
	input  wire emac_irq_pkg::mac_events_s EVENTS_IN,
	input  wire logic                  TX_ACTIVE_IN,
	// dma steering and interrupt
	output emac_irq_pkg::word_t        TX_DESC_ADDR_OUT,
	output logic                       RX_DESC_RETRY_OUT,
	output logic                       RX_RECLAIM_OUT,
	output logic                       IRQ_OUT
);
	import emac_irq_pkg::*;

	// expand byte strobes to a bit mask
	function automatic word_t strb_mask(
		input logic [3:0] strb
	);
		word_t m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// descriptor address from list start and buffer index
	function automatic word_t desc_addr(
		input word_t      base,
		input logic [9:0] idx
	);
		return base + {19'h0, idx, 3'h0};
	endfunction

	// true when an address names a mapped register
	function automatic logic is_mapped(
		input word_t a
	);
		return (a == `ADDR_TSR) || (a == `ADDR_TQP) ||
		       (a == `ADDR_RXSTAT) || (a == `ADDR_IRQSTAT) ||
		       (a == `ADDR_IRQEN) || (a == `ADDR_IRQDIS) ||
		       (a == `ADDR_IRQMASK);
	endfunction

	// bus-side state
	logic        awready_q;
	logic        wready_q;
	logic        aw_full_q;
	logic        w_full_q;
	word_t       aw_addr_q;
	word_t       w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	word_t       rdata_q;
	logic [1:0]  rresp_q;

	// register state
	word_t       base_q;
	word_t       base_d;
	logic [9:0]  idx_q;
	logic [9:0]  idx_d;
	word_t       frame_q;
	word_t       frame_d;
	word_t       desc_q;
	word_t       rxs_q;
	word_t       rxs_d;
	word_t       ist_q;
	word_t       ist_d;
	word_t       mask_q;
	word_t       mask_d;
	logic        retry_q;
	logic        retry_out_q;
	logic        reclaim_q;
	logic        irq_q;

	// decoded transfers
	logic        wr_go;
	logic        rd_go;
	word_t       wr_bits;
	word_t       wr_merged;
	logic        tqp_taken;
	word_t       ist_set;
	word_t       rxs_set;
	word_t       rd_val;
	logic        rxs_clr;
	logic        en_wr;
	logic        dis_wr;
	logic        ist_rd;

	// a write runs once address and data are both held
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign rd_go = ARVALID_IN && arready_q;
	assign wr_bits = w_data_q & strb_mask(w_strb_q);
	assign wr_merged = (base_q & ~strb_mask(w_strb_q)) | wr_bits;
	assign tqp_taken = wr_go && (aw_addr_q == `ADDR_TQP) &&
	                   !TX_ACTIVE_IN; // RQ2 RQ23

	// per-register write and read strobes
	assign rxs_clr = wr_go && (aw_addr_q == `ADDR_RXSTAT);
	assign en_wr   = wr_go && (aw_addr_q == `ADDR_IRQEN);
	assign dis_wr  = wr_go && (aw_addr_q == `ADDR_IRQDIS);
	assign ist_rd  = rd_go && (ARADDR_IN == `ADDR_IRQSTAT);

	// write address channel
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (AWVALID_IN && awready_q) begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b1;
			aw_addr_q <= AWADDR_IN;
		end else if (wr_go) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
		end
	end

	// write data channel
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
		end else if (WVALID_IN && wready_q) begin
			wready_q <= 1'b0;
			w_full_q <= 1'b1;
			w_data_q <= WDATA_IN;
			w_strb_q <= WSTRB_IN;
		end else if (wr_go) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
		end
	end

	// write response channel
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= is_mapped(aw_addr_q) ? `RESP_OKAY :
			            `RESP_SLVERR;
		end else if (BREADY_IN) begin
			bvalid_q <= 1'b0;
		end
	end

	// read value mux; write-only registers read as zero
	// decoded from the request so data is ready at the accept edge
	always_comb begin
		rd_val = '0;
		case (ARADDR_IN)
			`ADDR_TSR: rd_val[`TSR_ACTIVE] = TX_ACTIVE_IN; // RQ23
			`ADDR_TQP: rd_val = frame_q; // RQ4
			`ADDR_RXSTAT: rd_val = rxs_q;
			`ADDR_IRQSTAT: rd_val = ist_q;
			`ADDR_IRQMASK: rd_val = mask_q; // RQ22
			default:   rd_val = '0;
		endcase
	end

	// read address and data channels
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= `RESP_OKAY;
		end else if (rd_go) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_val;
			rresp_q   <= is_mapped(ARADDR_IN) ? `RESP_OKAY :
			             `RESP_SLVERR;
		end else if (rvalid_q && RREADY_IN) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// transmit queue pointer next state
	always_comb begin
		base_d  = base_q;
		idx_d   = idx_q;
		frame_d = frame_q;
		if (EVENTS_IN.tx_buf_used) begin
			if (EVENTS_IN.tx_buf_wrap) begin
				idx_d = 10'h000; // RQ1
			end else if (idx_q == `TQ_LAST_IDX) begin
				idx_d = 10'h000; // RQ1
			end else begin
				idx_d = idx_q + 10'h001; // RQ1
			end
		end
		if (EVENTS_IN.tx_complete) begin
			frame_d = desc_addr(base_q, idx_d); // RQ4
		end
		if (tqp_taken) begin
			base_d  = wr_merged; // RQ1
			idx_d   = 10'h000;
			frame_d = wr_merged;
		end
	end

	// transmit queue pointer registers
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			base_q  <= `TQP_RST;
			idx_q   <= 10'h000;
			frame_q <= `TQP_RST;
			desc_q  <= `TQP_RST;
		end else begin
			base_q  <= base_d;
			idx_q   <= idx_d;
			frame_q <= frame_d;
			desc_q  <= desc_addr(base_d, idx_d); // RQ1
		end
	end

	// receive status: hardware sets, write one clears, set wins
	always_comb begin
		rxs_set = '0;
		rxs_set[`RXS_BUF_UNAVAIL]  = EVENTS_IN.rx_desc_owned; // RQ7
		rxs_set[`RXS_FRAME_STORED] = EVENTS_IN.rx_frame_stored; // RQ8
		rxs_set[`RXS_OVERRUN]      = EVENTS_IN.rx_overrun; // RQ9
		rxs_d = rxs_q;
		if (rxs_clr) begin
			rxs_d = rxs_q & ~wr_bits; // RQ5
		end
		rxs_d = (rxs_d | rxs_set) & `RXS_IMPL; // RQ5
	end

	// receive status register
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			rxs_q <= '0;
		end else begin
			rxs_q <= rxs_d;
		end
	end

	// descriptor retry after an owned descriptor, and buffer reclaim
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			retry_q     <= 1'b0;
			retry_out_q <= 1'b0;
			reclaim_q   <= 1'b0;
		end else begin
			if (EVENTS_IN.rx_desc_owned) begin
				retry_q <= 1'b1; // RQ6
			end else if (EVENTS_IN.rx_desc_ok) begin
				retry_q <= 1'b0; // RQ6
			end
			retry_out_q <= retry_q &&
			               EVENTS_IN.rx_frame_start; // RQ6
			reclaim_q   <= EVENTS_IN.rx_overrun; // RQ9
		end
	end

	// interrupt status sources
	always_comb begin
		ist_set = '0;
		ist_set[`IRQ_MGMT_DONE]  = EVENTS_IN.mgmt_done; // RQ19
		ist_set[`IRQ_RX_DONE]    = EVENTS_IN.rx_frame_stored; // RQ11
		ist_set[`IRQ_RX_OWNED]   = EVENTS_IN.rx_desc_owned; // RQ12
		ist_set[`IRQ_TX_OWNED]   = EVENTS_IN.tx_desc_owned; // RQ12
		ist_set[`IRQ_TX_UNDER]   = EVENTS_IN.tx_late_data |
		                           EVENTS_IN.tx_bus_error |
		                           EVENTS_IN.tx_owned_mid |
		                           tqp_taken; // RQ13
		ist_set[`IRQ_RETRY_LIM]  = EVENTS_IN.retry_limit;
		ist_set[`IRQ_TX_EXHAUST] = EVENTS_IN.tx_exhausted; // RQ14
		ist_set[`IRQ_TX_DONE]    = EVENTS_IN.tx_complete; // RQ15
		ist_set[`IRQ_RX_OVERRUN] = EVENTS_IN.rx_overrun; // RQ16
		ist_set[`IRQ_BUS_ERROR]  = EVENTS_IN.rx_bus_error |
		                           EVENTS_IN.tx_bus_error; // RQ17
		ist_set[`IRQ_PAUSE_RX]   = EVENTS_IN.pause_received; // RQ18
		ist_set[`IRQ_PAUSE_ZERO] = EVENTS_IN.pause_zero; // RQ18
	end

	// interrupt status: cleared by read, a same-cycle event survives
	always_comb begin
		ist_d = ist_q;
		if (ist_rd) begin
			ist_d = '0; // RQ11
		end
		ist_d = (ist_d | ist_set) & `IRQ_IMPL; // RQ10
	end

	// interrupt status register
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			ist_q <= '0;
		end else begin
			ist_q <= ist_d;
		end
	end

	// mask: enable clears bits, disable sets them, zeros ignored
	always_comb begin
		mask_d = mask_q;
		if (en_wr) begin
			mask_d = mask_q & ~wr_bits; // RQ20 RQ22 RQ24
		end
		if (dis_wr) begin
			mask_d = mask_q | wr_bits; // RQ21 RQ22 RQ24
		end
		mask_d = mask_d & `IRQ_IMPL;
	end

	// mask register, every source masked out of reset
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			mask_q <= `MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	// interrupt line from the next status and mask
	// next state keeps the line in step with the flag, not a cycle late
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(ist_d & ~mask_d); // RQ24
		end
	end

	// outputs straight from flops
	assign AWREADY_OUT       = awready_q;
	assign WREADY_OUT        = wready_q;
	assign BVALID_OUT        = bvalid_q;
	assign BRESP_OUT         = bresp_q;
	assign ARREADY_OUT       = arready_q;
	assign RVALID_OUT        = rvalid_q;
	assign RDATA_OUT         = rdata_q;
	assign RRESP_OUT         = rresp_q;
	assign TX_DESC_ADDR_OUT  = desc_q;
	assign RX_DESC_RETRY_OUT = retry_out_q;
	assign RX_RECLAIM_OUT    = reclaim_q;
	assign IRQ_OUT           = irq_q;
endmodule
`default_nettype wire

// *** tb/emac_regs_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module emac_regs_chk import emac_irq_pkg::*; (
	// clock, reset and bus handshakes
	input wire logic        MCLK_IN,
	input wire logic        RESETN_IN,
	input wire logic        AWVALID_IN,
	input wire logic        AWREADY_OUT,
	input wire logic        WVALID_IN,
	input wire logic        WREADY_OUT,
	input wire logic        BVALID_OUT,
	input wire logic        BREADY_IN,
	input wire logic        ARVALID_IN,
	input wire logic        ARREADY_OUT,
	input wire logic        RVALID_OUT,
	input wire logic        RREADY_IN,
	// engine events and steering
	input wire mac_events_s EVENTS_IN,
	input wire word_t       TX_DESC_ADDR_OUT,
	input wire logic        RX_DESC_RETRY_OUT,
	input wire logic        RX_RECLAIM_OUT
);
	logic pend_q;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// failed descriptor attempt outstanding; a new failure wins
	always_ff @(posedge MCLK_IN)
		if (!RESETN_IN) pend_q <= 1'b0;
		else if (EVENTS_IN.rx_desc_owned) pend_q <= 1'b1;
		else if (EVENTS_IN.rx_desc_ok) pend_q <= 1'b0;
	// read answers one edge after the request, write response two edges after; gone after acceptance
	a_write_answer: assert property (AWVALID_IN && AWREADY_OUT &&
		WVALID_IN && WREADY_OUT |=> (!AWREADY_OUT && !WREADY_OUT) ##1
		(BVALID_OUT && AWREADY_OUT)) else $error("no bresp");
	a_write_close: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT)
		else $error("bvalid stuck");
	a_read_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT
		&& !ARREADY_OUT) else $error("no rvalid");
	a_read_close: assert property (RVALID_OUT && RREADY_IN |=> !RVALID_OUT
		&& ARREADY_OUT) else $error("rvalid stuck");
	// dma steering pulses
	a_reclaim_pulse: assert property (EVENTS_IN.rx_overrun |=> RX_RECLAIM_OUT)
		else $error("no reclaim");
	a_retry_due: assert property (EVENTS_IN.rx_frame_start && pend_q
		&& !EVENTS_IN.rx_desc_ok |=> RX_DESC_RETRY_OUT) else $error("no retry");
	a_retry_cause: assert property (RX_DESC_RETRY_OUT |->
		$past(EVENTS_IN.rx_frame_start) && $past(pend_q)) else $error("bad retry");
	// descriptor address steps by one descriptor or wraps after 1024
	a_ptr_step: assert property (EVENTS_IN.tx_buf_used && !EVENTS_IN.tx_buf_wrap
		&& AWREADY_OUT && WREADY_OUT |=> TX_DESC_ADDR_OUT ==
		$past(TX_DESC_ADDR_OUT) + 32'h8 || TX_DESC_ADDR_OUT ==
		$past(TX_DESC_ADDR_OUT) - 32'h1ff8) else $error("bad step");
	a_ptr_still: assert property (!EVENTS_IN.tx_buf_used && AWREADY_OUT
		&& WREADY_OUT |=> $stable(TX_DESC_ADDR_OUT)) else $error("ptr moved");
	c_write: cover property (BVALID_OUT && BREADY_IN);
	c_retry: cover property (RX_DESC_RETRY_OUT);
	c_reclaim: cover property (RX_RECLAIM_OUT);
endmodule
bind emac_status_interrupt_regs emac_regs_chk chk (.MCLK_IN, .RESETN_IN,
	.AWVALID_IN, .AWREADY_OUT, .WVALID_IN, .WREADY_OUT, .BVALID_OUT,
	.BREADY_IN, .ARVALID_IN, .ARREADY_OUT, .RVALID_OUT, .RREADY_IN,
	.EVENTS_IN, .TX_DESC_ADDR_OUT, .RX_DESC_RETRY_OUT, .RX_RECLAIM_OUT);
`default_nettype wire

// *** tb/mac_engine_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mac_engine_model (
	// system clock
	input wire logic                   clk_in,
	// event pulses and transmit state
	output emac_irq_pkg::mac_events_s  events_out,
	output var logic                   tx_active_out
);
	import emac_irq_pkg::*;
	initial begin
		events_out = '0;
		tx_active_out = 1'b0;
	end
	// hold events for n edges; each edge held counts once
	task automatic fire(input logic [17:0] v, input int n);
		@(posedge clk_in);
		events_out <= v;
		repeat (n) @(posedge clk_in);
		events_out <= '0;
	endtask
	// transmitter activity level
	task automatic busy(input logic b);
		@(posedge clk_in);
		tx_active_out <= b;
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	import emac_irq_pkg::*;
	localparam word_t R_PTR = 32'hfffc401c, R_RXF = 32'hfffc4020;
	localparam word_t R_IST = 32'hfffc4024, R_IEN = 32'hfffc4028;
	localparam word_t R_IDS = 32'hfffc402c, R_IMK = 32'hfffc4030;
	localparam word_t R_TST = 32'hfffc4014, R_BAD = 32'hfffc4040;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	word_t awa = '0, wd = '0, ara = '0, d;
	logic [1:0] rs;
	logic [3:0] ws = 4'hf;
	wire logic awr, wrd, bv, arr, rv, rtry, rcl, irq, act;
	wire logic [1:0] br, rr;
	wire word_t rdat, tda;
	wire mac_events_s ev;
	int err_count = 0, checks_done = 0;
	int ev_bit[14] = '{17, 16, 15, 10, 9, 8, 7, 6, 5, 2, 12, 11, 1, 0};
	word_t ex[14] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h810, 32'h10,
		32'h40, 32'h80, 32'h20, 32'h400, 32'h800, 32'h1000, 32'h2000};
	always #20 clk = ~clk;
	emac_status_interrupt_regs uut (.MCLK_IN(clk), .RESETN_IN(rst_n),
		.AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd),
		.WSTRB_IN(ws), .WVALID_IN(wv), .WREADY_OUT(wrd), .BRESP_OUT(br),
		.BVALID_OUT(bv), .BREADY_IN(bre), .ARADDR_IN(ara), .ARVALID_IN(arv),
		.ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rr), .RVALID_OUT(rv),
		.RREADY_IN(rre), .EVENTS_IN(ev), .TX_ACTIVE_IN(act),
		.TX_DESC_ADDR_OUT(tda), .RX_DESC_RETRY_OUT(rtry),
		.RX_RECLAIM_OUT(rcl), .IRQ_OUT(irq));
	mac_engine_model mac (.clk_in(clk), .events_out(ev), .tx_active_out(act));
	// bus write: each half released when taken, response kept in rs
	task automatic wr(input word_t a, v);
		logic aw, w;
		aw = 1;
		w = 1;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awr) begin
				aw = 0;
				awv <= 0;
			end
			if (w && wrd) begin
				w = 0;
				wv <= 0;
			end
		end
		do @(posedge clk); while (!bv);
		rs = br;
		bre <= 0;
	endtask
	// bus read into d and rs
	task automatic rd(input word_t a);
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rre <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		d = rdat;
		rs = rr;
		rre <= 0;
	endtask
	task automatic rc(input word_t a, e);
		rd(a);
		`CHK($sformatf("rd %h", a), e, d)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		rc(R_IMK, 32'h3cff);
		rc(R_RXF, 32'h0);
		wr(R_IEN, 32'h3cff);
		rc(R_IMK, 32'h0);
		wr(R_IDS, 32'h1);
		wr(R_IEN, 32'h0);
		rc(R_IMK, 32'h1);
		rc(R_IEN, 32'h0);
		// every source sets its bit; management source stays masked
		for (int i = 0; i < 14; i++) begin
			mac.fire(18'h1 << ev_bit[i], 1);
			@(negedge clk);
			`CHK("irq", i > 0, irq)
			rc(R_IST, ex[i]);
			rc(R_IST, 32'h0);
		end
		// receive flags: repeated failure, stored frame, overrun
		mac.fire(18'h08000, 2);
		mac.fire(18'h10000, 1);
		mac.fire(18'h01000, 1);
		@(negedge clk);
		`CHK("reclaim", 1'b1, rcl)
		rc(R_RXF, 32'h7);
		wr(R_RXF, 32'h2);
		rc(R_RXF, 32'h5);
		wr(R_RXF, 32'h7);
		rc(R_RXF, 32'h0);
		mac.fire(18'h08000, 1);
		rc(R_RXF, 32'h1);
		mac.fire(18'h04000, 1);
		@(negedge clk);
		`CHK("retry", 1'b1, rtry)
		mac.fire(18'h02000, 1);
		mac.fire(18'h04000, 1);
		@(negedge clk);
		`CHK("retry", 1'b0, rtry)
		rd(R_IST);
		// pointer write while idle, then stepping and wrapping
		wr(R_PTR, 32'h00010000);
		rc(R_PTR, 32'h00010000);
		rc(R_IST, 32'h10);
		mac.fire(18'h10, 3);
		@(negedge clk);
		`CHK("desc", 32'h00010018, tda)
		rc(R_PTR, 32'h00010000);
		mac.fire(18'h20, 1);
		rc(R_PTR, 32'h00010018);
		mac.fire(18'h18, 1);
		@(negedge clk);
		`CHK("desc", 32'h00010000, tda)
		mac.fire(18'h10, 1023);
		@(negedge clk);
		`CHK("desc", 32'h00011ff8, tda)
		mac.fire(18'h10, 1);
		@(negedge clk);
		`CHK("desc", 32'h00010000, tda)
		rd(R_IST);
		// busy transmitter ignores a pointer write
		mac.busy(1);
		rc(R_TST, 32'h8);
		wr(R_PTR, 32'h00020000);
		rc(R_PTR, 32'h00010018);
		rc(R_IST, 32'h0);
		`CHK("desc", 32'h00010000, tda)
		// byte strobes gate a disable write to its second byte
		ws <= 4'h2;
		wr(R_IDS, 32'h3cff);
		ws <= 4'hf;
		rc(R_IMK, 32'h3c01);
		// unmapped place answers with an error
		wr(R_BAD, 32'h1);
		`CHK("bresp", 2'h2, rs)
		rc(R_BAD, 32'h0);
		`CHK("rresp", 2'h2, rs)
		tally_and_finish;
	end
endmodule
`undef CHK
`default_nettype wire
